// ==== logic/adc_mode_pkg.sv ====
/*
  Constants, types and helpers shared by the mode-control decoder and its
  serial front end. Assumes a 16-bit mode-control word that arrives MSB first.
*/
package adc_mode_pkg;

  // ---------------------------------------------------------------------
  // Word layout
  // ---------------------------------------------------------------------
  localparam int WORD_W = 16;
  localparam int SEL_BIT = 15;
  localparam int SCAN_HI = 14;
  localparam int SCAN_LO = 11;
  localparam int CHAN_HI = 10;
  localparam int CHAN_LO = 7;
  localparam int RST_HI = 6;
  localparam int RST_LO = 5;
  localparam int PM_HI = 4;
  localparam int PM_LO = 3;
  localparam int TAG_BIT = 2;
  localparam int SWC_BIT = 1;
  localparam int CHAN_W = 4;
  localparam int RESULT_W = 12;

  // ---------------------------------------------------------------------
  // Link timing and early-capture layout
  // ---------------------------------------------------------------------
  localparam int STEP_FALL_EDGE = 13;
  localparam int STEP_W = 9;
  localparam int STEP_SHIFT = 4;
  localparam int STEP_SEL = 8;
  localparam int STEP_SCAN_HI = 7;
  localparam int STEP_SCAN_LO = 4;
  localparam int STEP_CHAN_HI = 3;
  localparam int STEP_CHAN_LO = 0;

  // ---------------------------------------------------------------------
  // Field codes and reset values
  // ---------------------------------------------------------------------
  localparam logic [1:0] RESET_NONE = 2'h0;
  localparam logic [1:0] RESET_FIFO = 2'h1;
  localparam logic [1:0] RESET_ALL = 2'h2;
  localparam logic [1:0] PM_DEFAULT = 2'h0;
  localparam logic [1:0] PM_NORMAL = 2'h0;
  localparam logic [3:0] CHAN_DEFAULT = 4'h0;
  localparam logic [4:0] REPEAT_UNIT = 5'h4;
  localparam logic [3:0] SYNC_RESET = 4'hc;
  localparam int SY_CS = 3;
  localparam int SY_PIN = 2;
  localparam int SY_RX = 1;
  localparam int SY_STEP = 0;

  typedef enum logic [3:0] {
    SCAN_NULL = 4'h0,
    SCAN_MANUAL = 4'h1,
    SCAN_REPEAT = 4'h2,
    SCAN_STD_INT = 4'h3
  } scan_code_t;

  localparam scan_code_t SCAN_DEFAULT = SCAN_MANUAL;

  typedef enum logic [1:0] {
    ENG_IDLE = 2'b00,
    ENG_LAUNCH = 2'b01,
    ENG_WAIT = 2'b11
  } eng_state_t;

  // Modes that run from the internal clock
  function automatic logic is_internal(scan_code_t m);
    return (m == SCAN_REPEAT) || (m == SCAN_STD_INT);
  endfunction

  // Output word: tagged or left-justified result
  function automatic logic [WORD_W-1:0] format_result(logic [CHAN_W-1:0] chan,
                                                      logic [RESULT_W-1:0] res,
                                                      logic tag);
    return tag ? {chan, res} : {res, CHAN_DEFAULT};
  endfunction

endpackage

// ==== logic/mode_link_port.sv ====
/*
  Serial front end on the link clock: shifts the word in on rising edges,
  drives the answer out on falling edges, and hands words and the early
  channel capture to the core as toggles. Assumes the serial clock idles
  between frames and tx_word_i stays still while chip select is low.
*/
module mode_link_port
  import adc_mode_pkg::*;
(
  // Link side
  input wire logic sclk_i,
  input wire logic cs_n_i,
  input wire logic din_i,
  output logic dout_o,
  // Core side
  input wire logic reset_n_i,
  input wire logic [WORD_W-1:0] tx_word_i,
  output logic [WORD_W-1:0] rx_word_o,
  output logic rx_toggle_o,
  output logic [STEP_W-1:0] step_bits_o,
  output logic step_toggle_o
);

  // ---------------------------------------------------------------------
  // Frame-scoped state
  // ---------------------------------------------------------------------
  logic frame_clr;
  logic [WORD_W-1:0] shift_reg;
  logic [4:0] rise_cnt_reg;
  logic [4:0] fall_cnt_reg;
  logic out_bit_reg;
  logic [WORD_W-1:0] tx_shift;

  // Chip select high ends the frame without needing a clock edge
  assign frame_clr = cs_n_i | ~reset_n_i;
  assign tx_shift = tx_word_i << (fall_cnt_reg + 5'h1);

  // Input shifter and edge count
  always_ff @(posedge sclk_i or posedge frame_clr) begin
    if (frame_clr) begin
      shift_reg <= '0;
      rise_cnt_reg <= '0;
    end else begin
      shift_reg <= {shift_reg[WORD_W-2:0], din_i};
      if (rise_cnt_reg != 5'(WORD_W)) begin
        rise_cnt_reg <= rise_cnt_reg + 5'h1;
      end
    end
  end

  // Whole word hand-over on the last rising edge
  always_ff @(posedge sclk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      rx_word_o <= '0;
      rx_toggle_o <= 1'b0;
    end else if (!cs_n_i && rise_cnt_reg == 5'(WORD_W - 1)) begin
      rx_word_o <= {shift_reg[WORD_W-2:0], din_i};
      rx_toggle_o <= ~rx_toggle_o;
    end
  end

  // Falling-edge count and serial output
  always_ff @(negedge sclk_i or posedge frame_clr) begin
    if (frame_clr) begin
      fall_cnt_reg <= '0;
      out_bit_reg <= 1'b0;
    end else begin
      if (fall_cnt_reg != 5'(WORD_W)) begin
        fall_cnt_reg <= fall_cnt_reg + 5'h1;
      end
      out_bit_reg <= tx_shift[WORD_W-1];
    end
  end

  // Early capture of select, scan and channel bits for the mux step
  always_ff @(negedge sclk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      step_bits_o <= '0;
      step_toggle_o <= 1'b0;
    end else if (!cs_n_i && fall_cnt_reg == 5'(STEP_FALL_EDGE - 1)) begin // see R11
      step_bits_o <= shift_reg[STEP_SHIFT+STEP_W-1:STEP_SHIFT];
      step_toggle_o <= ~step_toggle_o;
    end
  end

  // First bit is presented before any clock edge
  assign dout_o = (fall_cnt_reg == 5'h0) ? tx_word_i[WORD_W-1] : out_bit_reg;

endmodule

// ==== logic/adc_mode_control_decode.sv ====
/*
  Mode-control word decoder and conversion sequencer: holds the decoded
  fields, runs manual, repeat and standard-internal scans, and keeps the
  result FIFO. Assumes a converter core on core_clk_i that answers each
  convert_start_o with one adc_result_valid_i pulse.
*/
// Operation
// R1 - External clock: power field, default zero, picks normal or power-down behaviour.
// R2 - Tag bit set: output is 4-bit channel then 12-bit result MSB first.
// R3 - Internal clock: every result carries its channel number regardless of tag bit.
// R4 - Internal clock: software-convert bit starts conversion at chip-select rising edge.
// R5 - Host rewrites software-convert for each further conversion; bit is one-shot.
// R6 - Null scan code keeps previous scan mode and ignores scan part of low bits.
// R7 - Null scan code still updates reset, power, tag and software-convert fields.
// R8 - Manual: one channel named per frame, result returned next frame, no averaging.
// R9 - Repeat: internal clock, converts one channel the configured count into FIFO.
// R10 - Standard-internal: converts channels zero up to last channel ascending into FIFO.
// R11 - Mux switches to next channel on thirteenth falling serial clock edge.
// R12 - Standard modes treat channel field as the scan's last channel.
// R13 - Scan codes: 0 null, 1 manual, 2 repeat, 3 standard-internal.
// R14 - Bit zero of the word is ignored and has no effect.
module adc_mode_control_decode
  import adc_mode_pkg::*;
#(
  parameter int FIFO_DEPTH = 16
)
(
  // Core clock and reset
  input wire logic core_clk_i,
  input wire logic reset_n_i,
  // Serial link
  input wire logic sclk_i,
  input wire logic cs_n_i,
  input wire logic din_i,
  output logic dout_o,
  // Converter core
  input wire logic convert_start_pin_n_i,
  input wire logic [1:0] repeat_count_i,
  input wire logic [RESULT_W-1:0] adc_result_i,
  input wire logic adc_result_valid_i,
  output logic convert_start_o,
  output logic [CHAN_W-1:0] mux_channel_o,
  output logic [1:0] power_mode_o,
  output logic [3:0] scan_mode_o,
  output logic [$clog2(FIFO_DEPTH):0] fifo_count_o
);

  localparam int AW = $clog2(FIFO_DEPTH);

  // ---------------------------------------------------------------------
  // Link front end and crossings
  // ---------------------------------------------------------------------
  logic [WORD_W-1:0] rx_word;
  logic rx_toggle;
  logic [STEP_W-1:0] step_bits;
  logic step_toggle;
  logic [WORD_W-1:0] tx_word_reg;
  logic [3:0] sync1_reg;
  logic [3:0] sync2_reg;
  logic [3:0] sync3_reg;
  logic cs_rise;
  logic pin_fall;
  logic word_evt;
  logic step_evt;

  mode_link_port link_port (
    .sclk_i(sclk_i),
    .cs_n_i(cs_n_i),
    .din_i(din_i),
    .dout_o(dout_o),
    .reset_n_i(reset_n_i),
    .tx_word_i(tx_word_reg),
    .rx_word_o(rx_word),
    .rx_toggle_o(rx_toggle),
    .step_bits_o(step_bits),
    .step_toggle_o(step_toggle)
  );

  // Two-flop synchronisers plus one edge-detect stage
  always_ff @(posedge core_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      sync1_reg <= SYNC_RESET;
      sync2_reg <= SYNC_RESET;
      sync3_reg <= SYNC_RESET;
    end else begin
      sync1_reg <= {cs_n_i, convert_start_pin_n_i, rx_toggle, step_toggle};
      sync2_reg <= sync1_reg;
      sync3_reg <= sync2_reg;
    end
  end

  assign cs_rise = sync2_reg[SY_CS] & ~sync3_reg[SY_CS];
  assign pin_fall = ~sync2_reg[SY_PIN] & sync3_reg[SY_PIN];
  assign word_evt = sync2_reg[SY_RX] ^ sync3_reg[SY_RX];
  assign step_evt = sync2_reg[SY_STEP] ^ sync3_reg[SY_STEP];

  // ---------------------------------------------------------------------
  // Mode-control fields
  // ---------------------------------------------------------------------
  logic mode_word;
  scan_code_t scan_field;
  scan_code_t step_scan;
  logic [1:0] rst_field;
  scan_code_t scan_mode_reg;
  logic [CHAN_W-1:0] channel_pick_reg;
  logic [1:0] power_select_reg;
  logic channel_tag_enable_reg;
  logic sw_pending_reg;
  logic internal;
  logic manual;
  logic fifo_clear;

  assign mode_word = word_evt & ~rx_word[SEL_BIT];
  assign scan_field = scan_code_t'(rx_word[SCAN_HI:SCAN_LO]);
  assign rst_field = rx_word[RST_HI:RST_LO];
  assign step_scan = scan_code_t'(step_bits[STEP_SCAN_HI:STEP_SCAN_LO]);
  assign internal = is_internal(scan_mode_reg);
  assign manual = scan_mode_reg == SCAN_MANUAL;
  assign fifo_clear = mode_word && (rst_field == RESET_FIFO || rst_field == RESET_ALL);

  // Field register update; bit zero is never read
  always_ff @(posedge core_clk_i or negedge reset_n_i) begin // see R14
    if (!reset_n_i) begin
      scan_mode_reg <= SCAN_DEFAULT;
      channel_pick_reg <= CHAN_DEFAULT;
      power_select_reg <= PM_DEFAULT;
      channel_tag_enable_reg <= 1'b0;
    end else if (mode_word && rst_field == RESET_ALL) begin
      scan_mode_reg <= SCAN_DEFAULT;
      channel_pick_reg <= CHAN_DEFAULT;
      power_select_reg <= PM_DEFAULT;
      channel_tag_enable_reg <= 1'b0;
    end else if (mode_word) begin
      power_select_reg <= rx_word[PM_HI:PM_LO]; // see R1, R7
      channel_tag_enable_reg <= rx_word[TAG_BIT]; // see R7
      case (scan_field) // see R13
        SCAN_MANUAL, SCAN_REPEAT, SCAN_STD_INT: begin
          scan_mode_reg <= scan_field;
          channel_pick_reg <= rx_word[CHAN_HI:CHAN_LO]; // see R12
        end
        default: begin
          scan_mode_reg <= scan_mode_reg; // see R6
        end
      endcase
    end
  end

  // One-shot software trigger; a new request wins over the clear
  always_ff @(posedge core_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      sw_pending_reg <= 1'b0;
    end else if (mode_word && rst_field != RESET_ALL && rx_word[SWC_BIT]) begin
      sw_pending_reg <= 1'b1; // see R7
    end else if (cs_rise || (mode_word && rst_field == RESET_ALL)) begin
      sw_pending_reg <= 1'b0; // see R5
    end
  end

  // Power field acts only with the external clock
  always_ff @(posedge core_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      power_mode_o <= PM_DEFAULT;
    end else begin
      power_mode_o <= internal ? PM_NORMAL : power_select_reg; // see R1
    end
  end

  assign scan_mode_o = scan_mode_reg;

  // ---------------------------------------------------------------------
  // Conversion sequencer
  // ---------------------------------------------------------------------
  eng_state_t eng_state;
  logic [CHAN_W-1:0] mux_channel_reg;
  logic [CHAN_W-1:0] last_channel_reg;
  logic [CHAN_W-1:0] launch_chan_reg;
  logic [4:0] left_reg;
  logic start_req;
  logic fifo_full;
  logic push;
  logic step_take;
  logic [AW:0] fifo_count_reg;

  assign start_req = internal && ((sw_pending_reg && cs_rise) ||
                                  (!sw_pending_reg && pin_fall)); // see R4
  assign convert_start_o = (eng_state == ENG_LAUNCH) && !(internal && fifo_full);
  assign push = (eng_state == ENG_WAIT) && adc_result_valid_i && internal;
  assign step_take = step_evt && !step_bits[STEP_SEL] && eng_state != ENG_LAUNCH &&
                     step_scan == SCAN_MANUAL; // see R6, R11
  assign mux_channel_o = mux_channel_reg;

  // Sequencer state
  always_ff @(posedge core_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      eng_state <= ENG_IDLE;
    end else begin
      case (eng_state)
        ENG_IDLE: begin
          if ((manual && cs_rise) || start_req) begin // see R8
            eng_state <= ENG_LAUNCH;
          end
        end
        ENG_LAUNCH: begin
          if (convert_start_o) begin
            eng_state <= ENG_WAIT;
          end
        end
        ENG_WAIT: begin
          if (adc_result_valid_i) begin
            if (scan_mode_reg == SCAN_REPEAT && left_reg != 5'h1) begin
              eng_state <= ENG_LAUNCH; // see R9
            end else if (scan_mode_reg == SCAN_STD_INT &&
                         mux_channel_reg != last_channel_reg) begin
              eng_state <= ENG_LAUNCH; // see R10
            end else begin
              eng_state <= ENG_IDLE;
            end
          end
        end
        default: begin
          eng_state <= ENG_IDLE;
        end
      endcase
    end
  end

  // Mux channel, scan bounds and repeat count
  always_ff @(posedge core_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      mux_channel_reg <= CHAN_DEFAULT;
      last_channel_reg <= CHAN_DEFAULT;
      left_reg <= '0;
    end else if (eng_state == ENG_IDLE && start_req) begin
      if (scan_mode_reg == SCAN_REPEAT) begin
        mux_channel_reg <= channel_pick_reg; // see R9
        left_reg <= REPEAT_UNIT * (5'(repeat_count_i) + 5'h1);
      end else begin
        mux_channel_reg <= CHAN_DEFAULT; // see R10
        last_channel_reg <= channel_pick_reg; // see R12
      end
    end else if (push) begin
      left_reg <= left_reg - 5'h1;
      if (scan_mode_reg == SCAN_STD_INT && mux_channel_reg != last_channel_reg) begin
        mux_channel_reg <= mux_channel_reg + 4'h1; // see R10
      end
    end else if (step_take) begin
      mux_channel_reg <= step_bits[STEP_CHAN_HI:STEP_CHAN_LO]; // see R11
    end
  end

  // Channel that the running conversion belongs to
  always_ff @(posedge core_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      launch_chan_reg <= CHAN_DEFAULT;
    end else if (convert_start_o) begin
      launch_chan_reg <= mux_channel_reg;
    end
  end

  // ---------------------------------------------------------------------
  // Result FIFO and output word
  // ---------------------------------------------------------------------
  logic [WORD_W-1:0] fifo_mem [FIFO_DEPTH];
  logic [AW-1:0] wr_ptr_reg;
  logic [AW-1:0] rd_ptr_reg;
  logic tx_full_reg;
  logic tx_load;
  logic pop;

  assign fifo_full = fifo_count_reg == (AW+1)'(FIFO_DEPTH);
  assign tx_load = internal && !tx_full_reg && fifo_count_reg != '0 && sync2_reg[SY_CS];
  assign pop = tx_load;
  assign fifo_count_o = fifo_count_reg;

  // Storage writes; every entry carries its channel
  always_ff @(posedge core_clk_i) begin
    if (push) begin
      fifo_mem[wr_ptr_reg] <= format_result(launch_chan_reg, adc_result_i, 1'b1); // see R3
    end
  end

  // Pointers and occupancy
  always_ff @(posedge core_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
      fifo_count_reg <= '0;
    end else if (fifo_clear) begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
      fifo_count_reg <= '0;
    end else begin
      if (push) begin
        wr_ptr_reg <= wr_ptr_reg + 1'b1;
      end
      if (pop) begin
        rd_ptr_reg <= rd_ptr_reg + 1'b1;
      end
      if (push && !pop) begin
        fifo_count_reg <= fifo_count_reg + 1'b1;
      end else if (pop && !push) begin
        fifo_count_reg <= fifo_count_reg - 1'b1;
      end
    end
  end

  // Word shifted out in the next frame; FIFO loads need synchronised chip select high, manual results load on arrival
  always_ff @(posedge core_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      tx_word_reg <= '0;
      tx_full_reg <= 1'b0;
    end else begin
      if (cs_rise || fifo_clear) begin
        tx_full_reg <= 1'b0;
      end
      if (tx_load) begin
        tx_word_reg <= fifo_mem[rd_ptr_reg];
        tx_full_reg <= 1'b1;
      end else if (eng_state == ENG_WAIT && adc_result_valid_i && manual) begin
        tx_word_reg <= format_result(launch_chan_reg, adc_result_i,
                                     channel_tag_enable_reg); // see R2, R8
      end
    end
  end

  // ---------------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------------
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (!reset_n_i);

  sequence s_sw_trigger;
    sw_pending_reg && cs_rise && internal && eng_state == ENG_IDLE && !word_evt;
  endsequence

  sequence s_std_start;
    eng_state == ENG_IDLE && start_req && scan_mode_reg == SCAN_STD_INT;
  endsequence

  property p_power_update;
    mode_word && rst_field != RESET_ALL |=> power_select_reg == $past(rx_word[PM_HI:PM_LO]);
  endproperty
  a_power_update: assert property (p_power_update) else $error("power field not taken"); // see R1

  property p_null_keeps;
    mode_word && rst_field != RESET_ALL && scan_field == SCAN_NULL
      |=> $stable(scan_mode_reg) && $stable(channel_pick_reg);
  endproperty
  a_null_keeps: assert property (p_null_keeps) else $error("null code changed scan"); // see R6

  property p_decode_repeat;
    mode_word && rst_field != RESET_ALL && scan_field == SCAN_REPEAT
      |=> scan_mode_reg == SCAN_REPEAT && internal;
  endproperty
  a_decode_repeat: assert property (p_decode_repeat) else $error("repeat decode"); // see R13

  property p_manual_tag;
    eng_state == ENG_WAIT && adc_result_valid_i && manual && channel_tag_enable_reg
      |=> tx_word_reg == {launch_chan_reg, $past(adc_result_i)};
  endproperty
  a_manual_tag: assert property (p_manual_tag) else $error("tagged word wrong"); // see R2

  property p_internal_tag;
    push |=> fifo_mem[$past(wr_ptr_reg)][WORD_W-1:RESULT_W] == launch_chan_reg;
  endproperty
  a_internal_tag: assert property (p_internal_tag) else $error("FIFO entry untagged"); // see R3

  property p_sw_start;
    s_sw_trigger |=> eng_state == ENG_LAUNCH && !sw_pending_reg ##1 eng_state != ENG_IDLE;
  endproperty
  a_sw_start: assert property (p_sw_start) else $error("software start missed"); // see R4

  property p_repeat_chan;
    convert_start_o && scan_mode_reg == SCAN_REPEAT |-> mux_channel_reg == channel_pick_reg;
  endproperty
  a_repeat_chan: assert property (p_repeat_chan) else $error("repeat channel wrong"); // see R9

  property p_std_walk;
    s_std_start |=> mux_channel_reg == CHAN_DEFAULT && last_channel_reg == $past(channel_pick_reg);
  endproperty
  a_std_walk: assert property (p_std_walk) else $error("standard scan start wrong"); // see R12

  property p_std_step;
    push && scan_mode_reg == SCAN_STD_INT && mux_channel_reg != last_channel_reg
      |=> mux_channel_reg == $past(mux_channel_reg) + 4'h1;
  endproperty
  a_std_step: assert property (p_std_step) else $error("standard scan not ascending"); // see R10

  property p_mux_step;
    step_take && !push && !(eng_state == ENG_IDLE && start_req)
      |=> mux_channel_reg == $past(step_bits[STEP_CHAN_HI:STEP_CHAN_LO]);
  endproperty
  a_mux_step: assert property (p_mux_step) else $error("mux step missed"); // see R11

endmodule

// ==== tb/spi_host_model.sv ====
/*
  Serial host stand-in: one word per chip-select frame, answer sampled back.
  Assumes the device samples din on rising sclk and drives dout on falling.
*/
module spi_host_model (
  // Link pins
  output logic sclk_o,
  output logic cs_n_o,
  output logic din_o,
  input wire logic dout_i
);
  timeunit 1ns;
  timeprecision 1ns;
  // Idle link: clock stands low, chip select high
  initial begin
    sclk_o = 1'b0;
    cs_n_o = 1'b1;
    din_o = 1'b0;
  end
  // Sends a whole word; only a frame with a non-null scan code names a channel
  task automatic xfer(input logic [15:0] w, output logic [15:0] r);
    #7;
    cs_n_o = 1'b0;
    din_o = w[15];
    #24;
    for (int i = 15; i >= 0; i--) begin
      sclk_o = 1'b1;
      r[i] = dout_i;
      #24;
      sclk_o = 1'b0;
      if (i > 0) din_o = w[i-1];
      #24;
    end
    #100;
    cs_n_o = 1'b1;
    din_o = ~din_o;  // Released line shows the inverse of its last bit
    #400;
  endtask
endmodule

// ==== tb/test_adc_mode_control_decode.sv ====
/*
  Self-checking bench for the mode-control decoder: host frames on the link
  and a converter stand-in on the core clock. Assumes the logic/ files.
*/
module test_adc_mode_control_decode
  import adc_mode_pkg::*;
  ;
  timeunit 1ns;
  timeprecision 1ns;
  // Design signals and bench state
  logic core_clk_i = 1'b0;
  logic reset_n_i = 1'b0;
  logic sclk_i, cs_n_i, din_i, dout_o, convert_start_o;
  logic convert_start_pin_n_i = 1'b1;
  logic [1:0] repeat_count_i = 2'h1;
  logic [RESULT_W-1:0] adc_result_i = 12'h0;
  logic adc_result_valid_i = 1'b0;
  logic [CHAN_W-1:0] mux_channel_o;
  logic [CHAN_W-1:0] conv_chan = 4'h0;
  logic [1:0] power_mode_o;
  logic [3:0] scan_mode_o;
  logic [4:0] fifo_count_o;
  logic [15:0] rx;
  int conv_wait = 0, cycles = 0, miscompares = 0, tests_run = 0;
  // Device and host
  adc_mode_control_decode #(.FIFO_DEPTH(16)) dut (
    .core_clk_i(core_clk_i), .reset_n_i(reset_n_i), .sclk_i(sclk_i),
    .cs_n_i(cs_n_i), .din_i(din_i), .dout_o(dout_o),
    .convert_start_pin_n_i(convert_start_pin_n_i), .repeat_count_i(repeat_count_i),
    .adc_result_i(adc_result_i), .adc_result_valid_i(adc_result_valid_i),
    .convert_start_o(convert_start_o), .mux_channel_o(mux_channel_o),
    .power_mode_o(power_mode_o), .scan_mode_o(scan_mode_o), .fifo_count_o(fifo_count_o)
  );
  spi_host_model host (
    .sclk_o(sclk_i), .cs_n_o(cs_n_i), .din_o(din_i), .dout_i(dout_o)
  );
  // Core clock, 40 ns period
  always #20 core_clk_i = ~core_clk_i;
  // Converter stand-in answers three cycles after a launch; hang guard
  always @(posedge core_clk_i) begin
    cycles <= cycles + 1;
    if (convert_start_o === 1'b1) begin
      conv_chan <= mux_channel_o;
      conv_wait <= 3;
    end else if (conv_wait > 1) begin
      conv_wait <= conv_wait - 1;
    end else begin
      conv_wait <= 0;
    end
    if (conv_wait == 1 && convert_start_o !== 1'b1) begin
      adc_result_valid_i <= 1'b1;
      adc_result_i <= res_of(conv_chan);
    end else begin
      adc_result_valid_i <= 1'b0;
      adc_result_i <= ~adc_result_i;  // Not valid: keeps changing
    end
    if (cycles == 5000) begin
      miscompares++;
      end_of_test();
    end
  end
  // ------------------------------------------------------------------
  // Helpers
  // ------------------------------------------------------------------
  function automatic logic [11:0] res_of(logic [3:0] c);
    return {4'ha, c, ~c};
  endfunction
  function automatic logic [15:0] mk(logic [3:0] sc, ch, logic [1:0] rs, pm, logic tg, sw, b0);
    return {1'b0, sc, ch, rs, pm, tg, sw, b0};
  endfunction
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    tests_run++;
    if (got !== exp) begin
      miscompares++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic end_of_test();
    $display("tests_run %0d miscompares %0d", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  task automatic wait_fifo(input logic [4:0] n);
    for (int t = 0; t < 300 && fifo_count_o !== n; t++) begin
      @(posedge core_clk_i);
    end
  endtask
  // Main sequence
  initial begin
    repeat (10) @(posedge core_clk_i);
    reset_n_i <= 1'b1;
    repeat (4) @(posedge core_clk_i);
    chk(16'(scan_mode_o), 16'h1);
    chk(16'(power_mode_o), 16'h0);
    // Manual frames: each answer carries the channel named one frame before
    for (int c = 0; c < 5; c++) begin
      host.xfer(mk(4'h1, 4'(c * 3), 2'h0, 2'(c), 1'b1, 1'b0, c[0]), rx);
      if (c > 0) chk(rx, {4'(c * 3 - 3), res_of(4'(c * 3 - 3))});
      chk(16'(power_mode_o), 16'(c % 4));
      chk(16'(mux_channel_o), 16'(c * 3));
    end
    host.xfer(mk(4'h1, 4'h7, 2'h0, 2'h0, 1'b0, 1'b0, 1'b0), rx);
    chk(rx, {4'hc, res_of(4'hc)});
    // Null code keeps the scan mode but takes the power field
    host.xfer(mk(4'h0, 4'h5, 2'h0, 2'h3, 1'b0, 1'b0, 1'b0), rx);
    chk(rx, {res_of(4'h7), 4'h0});
    chk(16'(scan_mode_o), 16'h1);
    chk(16'(power_mode_o), 16'h3);
    // Repeat started by the software bit: eight tagged results
    host.xfer(mk(4'h2, 4'h9, 2'h0, 2'h0, 1'b0, 1'b1, 1'b0), rx);
    chk(rx, {res_of(4'h7), 4'h0});
    wait_fifo(5'h7);
    chk(16'(fifo_count_o), 16'h7);
    chk(16'(scan_mode_o), 16'h2);
    for (int k = 0; k < 8; k++) begin
      host.xfer(16'h0, rx);
      chk(rx, {4'h9, res_of(4'h9)});
    end
    host.xfer(16'h0, rx);
    repeat (60) @(posedge core_clk_i);
    chk(16'(fifo_count_o), 16'h0);
    // Standard-internal from the pin: channels zero up to the last one
    host.xfer(mk(4'h3, 4'h3, 2'h0, 2'h0, 1'b0, 1'b0, 1'b0), rx);
    chk(16'(scan_mode_o), 16'h3);
    @(posedge core_clk_i);
    convert_start_pin_n_i <= 1'b0;
    repeat (4) @(posedge core_clk_i);
    convert_start_pin_n_i <= 1'b1;
    wait_fifo(5'h3);
    for (int k = 0; k < 4; k++) begin
      host.xfer(16'h0, rx);
      chk(rx, {4'(k), res_of(4'(k))});
    end
    // Software bit in a null word restarts the scan; reset field clears FIFO
    host.xfer(mk(4'h0, 4'h0, 2'h0, 2'h0, 1'b0, 1'b1, 1'b0), rx);
    wait_fifo(5'h3);
    chk(16'(fifo_count_o), 16'h3);
    host.xfer(mk(4'h0, 4'h0, 2'h1, 2'h0, 1'b0, 1'b0, 1'b0), rx);
    chk(16'(fifo_count_o), 16'h0);
    chk(16'(scan_mode_o), 16'h3);
    // Reset-all field brings back manual mode
    host.xfer(mk(4'h2, 4'h0, 2'h2, 2'h0, 1'b0, 1'b0, 1'b0), rx);
    chk(16'(scan_mode_o), 16'h1);
    end_of_test();
  end
endmodule
